/* rtl/hbpwm_params.svh */
// Purpose: constants of the h-bridge pwm output-mode block
// Assumes: 32-bit avalon-mm slave, byte addresses
// Notes: types live in hbpwm_pkg
// How it works
// - reset disables channels, releases all pins
// - two pins: waveform plus static or released
// - pair n holds channels 2n and 2n+1
// - sign and duty from own duty register
// - dual only when both enabled, both 11
// - lone dual channel runs as full bridge
// - full modes: sign with recirculation_side picks pin
// - duty D[10:0], or D[8:2] in high-byte mode
// - high-byte mode: duty from high byte only
// - dual: copy pair at next overflow
// - repeated even writes replace earlier value
// - full: working duty reloads every overflow
// - half: one pin released, one waveform
// - half mode ignores the sign bit
// - released pin is not driven at all
// - mode 00 waveform on minus, 01 plus
// - recirculation_side 0 static high, 1 static low
// - dual load only after odd duty write
`ifndef HBPWM_PARAMS_SVH
`define HBPWM_PARAMS_SVH
`define HB_NCH 8
`define HB_NPAIR 4
`define HB_OFS_CTRL 8'h00
`define HB_OFS_PER 8'h04
`define HB_OFS_STAT 8'h08
`define HB_BASE_CHCTL 3'h1
`define HB_BASE_DUTY 3'h2
`define HB_CTRL_FAST 0
`define HB_CTRL_RECIRCULATION_SIDE 1
`define HB_DUTY_SIGN 15
`define HB_PER_RST 11'h000
`define HB_PRESCALE 1
`endif

/* rtl/hbpwm_pkg.sv */
// Purpose: shared types of the h-bridge pwm block
// Assumes: nothing
// Notes: mode code 3'h4 means channel off
`default_nettype none
package hbpwm_pkg;
	typedef enum logic [2:0] {
		HB_HALF_M = 3'h0,
		HB_HALF_P = 3'h1,
		HB_FULL = 3'h2,
		HB_DUAL = 3'h3,
		HB_OFF = 3'h4
	} hbpwm_mode_t;
	typedef struct packed {
		logic [1:0] output_mode_sel;
		logic [1:0] alignment_sel;
	} hbpwm_chcfg_t;
	typedef struct packed {
		logic p_out;
		logic p_oe;
		logic m_out;
		logic m_oe;
	} hbpwm_pins_t;
endpackage
`default_nettype wire

/* rtl/hbpwm_channel.sv */
// Purpose: one channel: waveform and pin steering
// Assumes: mode already resolved by the top
// Notes: pins are registered, one cycle after inputs
`include "hbpwm_params.svh"
`default_nettype none
module hbpwm_channel import hbpwm_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input var hbpwm_mode_t eff,
	input wire logic [1:0] align,
	input wire logic sign,
	input wire logic recirculation_side,
	input wire logic [10:0] duty,
	input wire logic [10:0] cnt,
	input wire logic [10:0] per,
	input wire logic ovf,
	output hbpwm_pins_t pins
);
	logic parity_reg;
	logic act_left, act_right, active, lvl, on_p;

	// center aligned starts on the even period after enable
	always_ff @(posedge clk) begin
		if (!reset_n || eff == HB_OFF)
			parity_reg <= 1'b0;
		else if (ovf)
			parity_reg <= ~parity_reg;
	end

	// duty >= period saturates to always active
	assign act_left = cnt < duty;
	assign act_right = (duty >= per) || (cnt >= per - duty);
	always_comb begin
		case (align)
			2'h1: active = act_left;
			2'h2: active = act_right;
			2'h3: active = parity_reg ? act_right : act_left;
			default: active = 1'b0;
		endcase
	end
	assign lvl = recirculation_side ? active : ~active; // active level follows recirculation_side
	assign on_p = sign ^ recirculation_side;

	// pin steering per resolved mode
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pins <= '0;
		end else begin
			case (eff)
				HB_HALF_M: pins <= '{p_out: 1'b0, p_oe: 1'b0, m_out: ~active, m_oe: 1'b1};
				HB_HALF_P: pins <= '{p_out: ~active, p_oe: 1'b1, m_out: 1'b0, m_oe: 1'b0};
				HB_FULL, HB_DUAL: begin
					// non-waveform pin static: high for recirculation_side 0, low for 1
					pins.p_out <= on_p ? lvl : ~recirculation_side;
					pins.m_out <= on_p ? ~recirculation_side : lvl;
					pins.p_oe <= 1'b1;
					pins.m_oe <= 1'b1;
				end
				default: pins <= '0;
			endcase
		end
	end

	a_off_released: assert property (@(posedge clk) disable iff (!reset_n)
		eff == HB_OFF |=> !pins.p_oe && !pins.m_oe)
		else $error("off channel still drives a pin");
	a_half_no_sign: assert property (@(posedge clk) disable iff (!reset_n)
		eff == HB_HALF_M |=> !pins.p_oe && pins.m_oe && pins.m_out == !$past(active))
		else $error("half mode reacted to sign");
	a_full_static: assert property (@(posedge clk) disable iff (!reset_n)
		(eff == HB_FULL || eff == HB_DUAL) && !on_p |=> pins.p_oe && pins.p_out == !$past(recirculation_side))
		else $error("static pin level wrong");
endmodule
`default_nettype wire

/* rtl/hbpwm_top.sv */
// Purpose: eight-channel h-bridge pwm output-mode logic
// Assumes: avalon-mm slave, byte address, one wait state
// Notes: pin 2c is channel c plus, pin 2c+1 is its minus
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`include "hbpwm_params.svh"
`default_nettype none
module hbpwm_top import hbpwm_pkg::*; #(
	parameter int PRESCALE = `HB_PRESCALE
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [2*`HB_NCH-1:0] pin_out,
	output logic [2*`HB_NCH-1:0] pin_oe
);
	localparam int NCH = `HB_NCH;
	localparam int NPAIR = `HB_NPAIR;

	logic ack_reg, acc, wr_ok;
	logic sel_chctl, sel_duty;
	logic [2:0] idx;
	logic [31:0] rd_next;
	logic fast_reg, recirculation_side_reg;
	logic [10:0] per_reg;
	hbpwm_chcfg_t channel_ctrl_reg [NCH];
	hbpwm_chcfg_t cfg_work [NCH];
	logic [11:0] duty_reg [NCH]; // sign, duty count
	logic [11:0] duty_work [NCH];
	logic [NPAIR-1:0] odd_wr_reg, dual_pair;
	hbpwm_mode_t eff [NCH];
	logic [NCH-1:0] chan_on;
	logic [7:0] pre_reg;
	logic tick, ovf, all_off;
	logic [10:0] cnt_reg;
	hbpwm_pins_t pins_w [NCH];

	// one wait state: request taken, answered next cycle
	assign acc = avs_read | avs_write;
	assign avs_waitrequest = acc & ~ack_reg;
	assign wr_ok = avs_write & ack_reg;
	assign sel_chctl = avs_address[7:5] == `HB_BASE_CHCTL;
	assign sel_duty = avs_address[7:5] == `HB_BASE_DUTY;
	assign idx = avs_address[4:2];

	always_ff @(posedge clk) begin
		if (!reset_n)
			ack_reg <= 1'b0;
		else
			ack_reg <= acc & ~ack_reg;
	end

	// read mux; unmapped words read zero
	always_comb begin
		rd_next = 32'h0000_0000;
		if (sel_chctl)
			rd_next = {24'h00_0000, channel_ctrl_reg[idx], 4'h0};
		else if (sel_duty && fast_reg)
			rd_next = {16'h0000, duty_reg[idx][11], duty_reg[idx][8:2], 8'h00};
		else if (sel_duty)
			rd_next = {16'h0000, duty_reg[idx][11], 4'h0, duty_reg[idx][10:0]};
		else if (avs_address == `HB_OFS_CTRL)
			rd_next = {30'h0, recirculation_side_reg, fast_reg};
		else if (avs_address == `HB_OFS_PER)
			rd_next = {21'h00_0000, per_reg};
		else if (avs_address == `HB_OFS_STAT)
			rd_next = {20'h0_0000, dual_pair, chan_on};
	end

	// read data captured in the wait cycle, stands at the answer
	always_ff @(posedge clk) begin
		if (!reset_n)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && !ack_reg)
			avs_readdata <= rd_next;
	end

	// global control and period
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			fast_reg <= 1'b0;
			recirculation_side_reg <= 1'b0;
			per_reg <= `HB_PER_RST;
		end else if (wr_ok) begin
			if (avs_address == `HB_OFS_CTRL && avs_byteenable[0]) begin
				fast_reg <= avs_writedata[`HB_CTRL_FAST];
				recirculation_side_reg <= avs_writedata[`HB_CTRL_RECIRCULATION_SIDE];
			end
			if (avs_address == `HB_OFS_PER) begin
				if (avs_byteenable[0])
					per_reg[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1])
					per_reg[10:8] <= avs_writedata[10:8];
			end
		end
	end

	// channel control and duty registers as software sees them
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int i = 0; i < NCH; i++) begin
				channel_ctrl_reg[i] <= '0;
				duty_reg[i] <= 12'h000;
			end
		end else if (wr_ok) begin
			if (sel_chctl && avs_byteenable[0])
				channel_ctrl_reg[idx] <= avs_writedata[7:4];
			if (sel_duty) begin
				// later writes simply overwrite, only the last is copied
				if (fast_reg && avs_byteenable[1]) begin
					// high byte alone defines duty, D10 D9 D1 D0 cleared
					duty_reg[idx] <= {avs_writedata[`HB_DUTY_SIGN], 2'h0, avs_writedata[14:8], 2'h0};
				end else if (!fast_reg) begin
					// byte writes here give mixed values, host avoids them
					if (avs_byteenable[1])
						duty_reg[idx][11:8] <= {avs_writedata[`HB_DUTY_SIGN], avs_writedata[10:8]};
					if (avs_byteenable[0])
						duty_reg[idx][7:0] <= avs_writedata[7:0];
				end
			end
		end
	end

	// prescaler: one-cycle tick enables the period counter
	assign tick = pre_reg == 8'(PRESCALE - 1);
	always_ff @(posedge clk) begin
		if (!reset_n || tick)
			pre_reg <= 8'h00;
		else
			pre_reg <= pre_reg + 8'h01;
	end

	// period counter; a zero period stops it and shuts all channels
	assign ovf = tick && per_reg != 11'h000 && cnt_reg == per_reg - 11'h001;
	always_ff @(posedge clk) begin
		if (!reset_n || per_reg == 11'h000 || ovf)
			cnt_reg <= 11'h000;
		else if (tick)
			cnt_reg <= cnt_reg + 11'h001;
	end

	// mode resolution from working configuration
	always_comb begin
		all_off = per_reg == 11'h000;
		for (int i = 0; i < NCH; i++) begin
			if (cfg_work[i].alignment_sel != 2'h0)
				all_off = 1'b0;
		end
		if (per_reg == 11'h000)
			all_off = 1'b1;
		for (int p = 0; p < NPAIR; p++) begin
			dual_pair[p] = cfg_work[2*p].alignment_sel != 2'h0 && cfg_work[2*p+1].alignment_sel != 2'h0 &&
				cfg_work[2*p].output_mode_sel == 2'h3 && cfg_work[2*p+1].output_mode_sel == 2'h3;
		end
		for (int i = 0; i < NCH; i++) begin
			chan_on[i] = cfg_work[i].alignment_sel != 2'h0 && per_reg != 11'h000;
			if (!chan_on[i])
				eff[i] = HB_OFF;
			else if (cfg_work[i].output_mode_sel == 2'h3 && dual_pair[i/2])
				eff[i] = HB_DUAL;
			else if (cfg_work[i].output_mode_sel[1])
				eff[i] = HB_FULL;
			else if (cfg_work[i].output_mode_sel[0])
				eff[i] = HB_HALF_P;
			else
				eff[i] = HB_HALF_M;
		end
	end

	// configuration copy: at once when the period is zero, else at overflow, also when no working channel is enabled
	always_ff @(posedge clk) begin
		for (int i = 0; i < NCH; i++) begin
			if (!reset_n)
				cfg_work[i] <= '0;
			else if (all_off || ovf)
				cfg_work[i] <= channel_ctrl_reg[i];
		end
	end

	// odd duty written since last overflow; a new write wins
	always_ff @(posedge clk) begin
		for (int p = 0; p < NPAIR; p++) begin
			if (!reset_n)
				odd_wr_reg[p] <= 1'b0;
			else if (wr_ok && sel_duty && idx == 3'(2*p+1))
				odd_wr_reg[p] <= 1'b1;
			else if (ovf)
				odd_wr_reg[p] <= 1'b0;
		end
	end

	// working duty: disabled loads at once, dual waits for odd write
	always_ff @(posedge clk) begin
		for (int i = 0; i < NCH; i++) begin
			if (!reset_n)
				duty_work[i] <= 12'h000;
			else if (per_reg == 11'h000 || channel_ctrl_reg[i].alignment_sel == 2'h0)
				duty_work[i] <= duty_reg[i];
			else if (ovf && eff[i] != HB_DUAL)
				duty_work[i] <= duty_reg[i];
			else if (ovf && odd_wr_reg[i/2])
				duty_work[i] <= duty_reg[i];
		end
	end

	// per-channel waveform and pins; oe low releases to the pin mux
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		hbpwm_channel u_ch (
			.clk(clk),
			.reset_n(reset_n),
			.eff(eff[c]),
			.align(cfg_work[c].alignment_sel),
			.sign(duty_work[c][11]),
			.recirculation_side(recirculation_side_reg),
			.duty(duty_work[c][10:0]),
			.cnt(cnt_reg),
			.per(per_reg),
			.ovf(ovf),
			.pins(pins_w[c])
		);
		assign pin_out[2*c] = pins_w[c].p_out;
		assign pin_oe[2*c] = pins_w[c].p_oe;
		assign pin_out[2*c+1] = pins_w[c].m_out;
		assign pin_oe[2*c+1] = pins_w[c].m_oe;
	end

	a_reset_release: assert property (@(posedge clk)
		!reset_n |=> pin_oe == 16'h0000)
		else $error("pins driven after reset");
	a_dual_hold: assert property (@(posedge clk) disable iff (!reset_n)
		ovf && eff[0] == HB_DUAL && !odd_wr_reg[0] && channel_ctrl_reg[0].alignment_sel != 2'h0
		|=> duty_work[0] == $past(duty_work[0]))
		else $error("dual pair loaded without odd write");
	a_full_reload: assert property (@(posedge clk) disable iff (!reset_n)
		ovf && eff[0] == HB_FULL |=> duty_work[0] == $past(duty_reg[0]))
		else $error("full mode duty not reloaded");
	a_fast_write: assert property (@(posedge clk) disable iff (!reset_n)
		wr_ok && sel_duty && idx == 3'h0 && fast_reg && avs_byteenable[1]
		|=> duty_reg[0][10:0] == {2'h0, $past(avs_writedata[14:8]), 2'h0})
		else $error("high-byte duty decode wrong");
	a_bus_answer: assert property (@(posedge clk) disable iff (!reset_n)
		acc && avs_waitrequest ##1 acc |-> !avs_waitrequest)
		else $error("bus answer later than one wait state");
endmodule
`default_nettype wire

/* testbench/hbpwm_bridge_model.sv */
// Purpose: external bridge drivers seen from the sixteen pins
// Assumes: a released pin floats, nothing pulls it
// Notes: floating pins toggle each clock so stale levels never match
`default_nettype none
module hbpwm_bridge_model (
	input wire logic clk,
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe,
	output logic [15:0] level
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] float_reg = 16'h0000;
	// free-running pattern for undriven pins
	always @(posedge clk) begin
		float_reg <= ~float_reg;
	end
	// driven pins follow the block, released ones float
	assign level = (pin_out & pin_oe) | (float_reg & ~pin_oe);
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: self-checking bench of the output-mode logic
// Assumes: period 4, prescale 1, static duty levels only
// Notes: duty 0 and duty equal to period give static pins
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] ch;
		logic [15:0] duty;
		logic [1:0] oe;
		logic [1:0] out;
	} hbpwm_row_t;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [15:0] pin_out;
	logic [15:0] pin_oe;
	logic [15:0] level;
	logic [31:0] q;
	int n_mismatch = 0;
	int comparisons = 0;
	hbpwm_row_t rows [10];
	always #10 clk = ~clk;
	hbpwm_top #(.PRESCALE(1)) dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pin_out(pin_out), .pin_oe(pin_oe));
	hbpwm_bridge_model bridge (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .level(level));
	task automatic give_verdict();
		if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		avs_byteenable <= be;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		// read data taken at the edge that ends the wait
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) n_mismatch++;
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	initial begin
		rows = '{'{8'h00, 8'h90, 16'h0000, 2'h3, 2'h3}, '{8'h00, 8'h90, 16'h0004, 2'h3, 2'h1},
			'{8'h00, 8'hA0, 16'h8004, 2'h3, 2'h2}, '{8'h02, 8'hB0, 16'h0004, 2'h3, 2'h1},
			'{8'h02, 8'h90, 16'h8004, 2'h3, 2'h2}, '{8'h02, 8'h90, 16'h0000, 2'h3, 2'h0},
			'{8'h00, 8'h10, 16'h8004, 2'h2, 2'h0}, '{8'h02, 8'h50, 16'h8004, 2'h1, 2'h0},
			'{8'h00, 8'hD0, 16'h0004, 2'h3, 2'h1}, '{8'h01, 8'h90, 16'h0100, 2'h3, 2'h1}};
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		chk("oe after reset", {16'h0000, pin_oe}, 32'h0);
		bus(8'h04, 1'b1, 32'h4, 4'h3);
		// each row: channel 0 off, set control, duty, then mode
		for (int i = 0; i < 10; i++) begin
			bus(8'h20, 1'b1, 32'h0, 4'h1);
			bus(8'h00, 1'b1, 32'(rows[i].ctl), 4'h1);
			bus(8'h40, 1'b1, 32'(rows[i].duty), rows[i].ctl[0] ? 4'h2 : 4'h3);
			bus(8'h20, 1'b1, 32'(rows[i].ch), 4'h1);
			waitc(20);
			chk("ch0 oe", 32'(pin_oe[1:0]), 32'(rows[i].oe));
			chk("ch0 level", 32'(level[1:0] & pin_oe[1:0]), 32'(rows[i].out));
			chk("other oe", 32'(pin_oe[15:2]), 32'h0);
		end
		bus(8'h40, 1'b0, 32'h0, 4'hF);
		chk("fast duty read", 32'(q[15:0]), 32'h0100);
		bus(8'h40, 1'b1, 32'hFF, 4'h1);
		bus(8'h40, 1'b0, 32'h0, 4'hF);
		chk("low byte write", 32'(q[15:0]), 32'h0100);
		bus(8'hFC, 1'b0, 32'h0, 4'hF);
		chk("unmapped read", q, 32'h0);
		// pair 0 in dual mode, duty 0 on both
		bus(8'h00, 1'b1, 32'h0, 4'h1);
		bus(8'h20, 1'b1, 32'h0, 4'h1);
		bus(8'h40, 1'b1, 32'h0, 4'h3);
		bus(8'h44, 1'b1, 32'h0, 4'h3);
		bus(8'h20, 1'b1, 32'hD0, 4'h1);
		bus(8'h24, 1'b1, 32'hD0, 4'h1);
		waitc(20);
		bus(8'h08, 1'b0, 32'h0, 4'hF);
		chk("status", 32'(q[11:0]), 32'h103);
		bus(8'h40, 1'b1, 32'h8004, 4'h3);
		bus(8'h40, 1'b1, 32'h0004, 4'h3);
		waitc(20);
		chk("dual hold", 32'(level[3:0]), 32'hF);
		bus(8'h44, 1'b1, 32'h0, 4'h3);
		waitc(20);
		chk("dual load", 32'(level[3:0]), 32'hD);
		// second reset while channels run
		@(posedge clk);
		reset_n <= 1'b0;
		waitc(2);
		chk("oe in reset", {16'h0000, pin_oe}, 32'h0);
		@(posedge clk);
		reset_n <= 1'b1;
		bus(8'h20, 1'b0, 32'h0, 4'hF);
		chk("ctrl after reset", q, 32'h0);
		waitc(8);
		chk("oe after second reset", {16'h0000, pin_oe}, 32'h0);
		give_verdict();
	end
	// cuts a hang short
	initial begin
		#100us;
		n_mismatch++;
		give_verdict();
	end
endmodule
`default_nettype wire
